//--- src/mps_pkg.sv
// Shared types and constants for the motion program sequencer.
// Assumes one clock (i_clk, 125 MHz) and a synchronous active-high reset.
package mps_pkg;

	// Command opcodes handed over by the program fetch logic
	typedef enum logic [3:0] {
		MPS_OP_NO_ACTION = 4'h0,
		MPS_OP_WAIT_STOP = 4'h1,
		MPS_OP_WAIT_POS = 4'h2,
		MPS_OP_PAUSE = 4'h3,
		MPS_OP_LAUNCH_Y = 4'h4,
		MPS_OP_JOIN_Y = 4'h5,
		MPS_OP_SPEED = 4'h6,
		MPS_OP_SET_POS = 4'h7
	} mps_op_t;

	// Acceleration profile currently used by the motion engine
	typedef enum logic [2:0] {
		MPS_PROF_CONST = 3'h0,
		MPS_PROF_TRAP1 = 3'h1,
		MPS_PROF_TRAP2 = 3'h2,
		MPS_PROF_TRAP3 = 3'h3,
		MPS_PROF_SCURVE1 = 3'h4,
		MPS_PROF_SCURVE2 = 3'h5
	} mps_prof_t;

	// Kind of move that is driving the motor
	typedef enum logic [1:0] {
		MPS_MOVE_OTHER = 2'h0,
		MPS_MOVE_CONT = 2'h1,
		MPS_MOVE_ABS_CONT = 2'h2,
		MPS_MOVE_REL_CONT = 2'h3
	} mps_move_t;

	// Latched error codes
	typedef enum logic [3:0] {
		MPS_ERR_NONE = 4'h0,
		MPS_ERR_WPOS_STOPPED = 4'h1,
		MPS_ERR_WPOS_HALTED = 4'h2,
		MPS_ERR_WPOS_PASSED = 4'h3,
		MPS_ERR_SPD_SCURVE = 4'h4,
		MPS_ERR_SPD_RANGE = 4'h5,
		MPS_ERR_SPD_MOVE = 4'h6,
		MPS_ERR_POS_ROTATING = 4'h7,
		MPS_ERR_WRONG_AXIS = 4'h8,
		MPS_ERR_LABEL = 4'h9,
		MPS_ERR_BAD_OP = 4'hA
	} mps_err_t;

	// Sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		MPS_ST_IDLE = 3'b000,
		MPS_ST_WSTOP = 3'b001,
		MPS_ST_WPOS = 3'b011,
		MPS_ST_WJOIN = 3'b010,
		MPS_ST_PAUSE = 3'b110
	} mps_state_t;

	localparam int MPS_POS_W = 32;
	localparam int MPS_SPD_W = 19;
	localparam int MPS_LABEL_W = 6;

	// Speed limits per microstep resolution setting
	localparam logic [3:0] MPS_USTEP_1 = 4'h1;
	localparam logic [3:0] MPS_USTEP_2 = 4'h2;
	localparam logic [MPS_SPD_W-1:0] MPS_SPD_MIN = 19'h00001;
	localparam logic [MPS_SPD_W-1:0] MPS_SPD_MAX_1 = 19'h1E848;
	localparam logic [MPS_SPD_W-1:0] MPS_SPD_MAX_2 = 19'h3D090;
	localparam logic [MPS_SPD_W-1:0] MPS_SPD_MAX_N = 19'h7A120;
	localparam logic [MPS_LABEL_W-1:0] MPS_LABEL_NONE = 6'h00;

	// One program line as handed to the sequencer
	typedef struct packed {
		mps_op_t op;
		logic standalone_y;
		logic [MPS_POS_W-1:0] data;
	} mps_cmd_t;

	// Live state reported by the motion engine
	typedef struct packed {
		logic rotating;
		logic dir_neg;
		logic [MPS_POS_W-1:0] position;
		mps_prof_t profile;
		mps_move_t move;
		logic [3:0] microstep;
	} mps_motion_t;

endpackage

//--- src/mps_pass_det.sv
// Position passage detector for the wait-for-position command.
// Assumes position and target are signed pulse counts on the same scale.
module mps_pass_det
	import mps_pkg::*;
(
	input wire logic [MPS_POS_W-1:0] i_position,
	input wire logic [MPS_POS_W-1:0] i_target,
	input wire logic i_dir_neg,
	output logic o_passed
);
	// Signed views of both counts
	logic signed [MPS_POS_W-1:0] pos_s;
	logic signed [MPS_POS_W-1:0] tgt_s;

	assign pos_s = i_position;
	assign tgt_s = i_target;
	// Reaching the target counts as passing it, in the travel direction
	assign o_passed = i_dir_neg ? (pos_s <= tgt_s) : (pos_s >= tgt_s);
endmodule // mps_pass_det

//--- src/mps_seq.sv
// Per-axis program command sequencer: waits, pause, axis join, speed and
// position rewrite. Assumes fetch logic, motion engine and host tool all
// run on i_clk; no pin reaches this block directly.

module mps_seq
	import mps_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_axis_is_y,
	input wire logic i_two_axis,
	input wire logic i_cmd_valid,
	input wire mps_pkg::mps_cmd_t i_cmd,
	input wire mps_pkg::mps_motion_t i_motion,
	input wire logic i_continue,
	input wire logic i_abort,
	input wire logic i_prog_start,
	input wire logic i_y_running,
	output logic o_ready,
	output logic o_advance,
	output logic o_error,
	output mps_pkg::mps_err_t o_err_code,
	output logic o_paused,
	output logic o_speed_wr,
	output logic o_speed_ramp,
	output logic [mps_pkg::MPS_SPD_W-1:0] o_speed,
	output logic o_pos_wr,
	output logic [mps_pkg::MPS_POS_W-1:0] o_pos,
	output logic o_y_start,
	output logic [mps_pkg::MPS_LABEL_W-1:0] o_y_label
);
	import mps_pkg::*;

	// Highest accepted speed for a microstep resolution setting
	function automatic logic [MPS_SPD_W-1:0] spd_limit(
		input logic [3:0] ustep);
		logic [MPS_SPD_W-1:0] lim;
		lim = MPS_SPD_MAX_N;
		if (ustep == MPS_USTEP_1) begin
			lim = MPS_SPD_MAX_1;
		end else if (ustep == MPS_USTEP_2) begin
			lim = MPS_SPD_MAX_2;
		end
		return lim;
	endfunction

	// True for either S-curve profile
	function automatic logic is_scurve(input mps_prof_t p);
		return (p == MPS_PROF_SCURVE1) || (p == MPS_PROF_SCURVE2);
	endfunction

	mps_state_t state; // Current sequencer state
	mps_state_t next_state;
	logic [MPS_POS_W-1:0] target; // Latched wait target
	logic [MPS_POS_W-1:0] next_target;
	logic wait_dir_neg; // Direction frozen at the start of a wait
	logic next_wait_dir_neg;
	logic next_advance;
	logic next_error;
	mps_err_t next_err_code;
	mps_err_t fail_code; // Code raised this cycle, if any
	logic next_speed_wr;
	logic next_speed_ramp;
	logic [MPS_SPD_W-1:0] next_speed;
	logic next_pos_wr;
	logic [MPS_POS_W-1:0] next_pos;
	logic next_y_start;
	logic [MPS_LABEL_W-1:0] next_y_label;

	// Decoded conditions
	logic take; // A command is taken this cycle
	logic ignored; // Standalone Y line inside a two-axis program
	logic start_passed; // Target already behind at command start
	logic wait_passed; // Target reached while waiting
	logic [MPS_SPD_W-1:0] req_speed;
	logic speed_high; // Data bits above the speed field are set
	logic speed_ok;
	logic cont_move;
	logic [MPS_LABEL_W-1:0] req_label;
	logic label_ok;

	assign take = (state == MPS_ST_IDLE) && i_cmd_valid && !i_abort;
	assign ignored = i_axis_is_y && i_two_axis && i_cmd.standalone_y;
	assign req_speed = i_cmd.data[MPS_SPD_W-1:0];
	assign speed_high = |i_cmd.data[MPS_POS_W-1:MPS_SPD_W];
	assign speed_ok = !speed_high && (req_speed >= MPS_SPD_MIN)
		&& (req_speed <= spd_limit(i_motion.microstep));
	assign cont_move = (i_motion.move != MPS_MOVE_OTHER);
	assign req_label = i_cmd.data[MPS_LABEL_W-1:0];
	assign label_ok = (req_label != MPS_LABEL_NONE)
		&& !(|i_cmd.data[MPS_POS_W-1:MPS_LABEL_W]);

	// Check at command start, using the live direction
	mps_pass_det u_start_det (
		.i_position(i_motion.position),
		.i_target(i_cmd.data),
		.i_dir_neg(i_motion.dir_neg),
		.o_passed(start_passed)
	);

	// Check while waiting, against the latched target; one cycle of
	// reaction is far inside the few milliseconds the user allows
	mps_pass_det u_wait_det (
		.i_position(i_motion.position),
		.i_target(target),
		.i_dir_neg(wait_dir_neg),
		.o_passed(wait_passed)
	);

	// Next-state and command decode
	always_comb begin
		next_state = state;
		next_target = target;
		next_wait_dir_neg = wait_dir_neg;
		next_advance = 1'b0;
		fail_code = MPS_ERR_NONE;
		next_speed_wr = 1'b0;
		next_speed_ramp = o_speed_ramp;
		next_speed = o_speed;
		next_pos_wr = 1'b0;
		next_pos = o_pos;
		next_y_start = 1'b0;
		next_y_label = o_y_label;
		case (state)
			MPS_ST_IDLE: begin
				if (take && ignored) begin
					next_advance = 1'b1;
				end else if (take) begin
					case (i_cmd.op)
						MPS_OP_NO_ACTION: begin
							next_advance = 1'b1;
						end
						MPS_OP_WAIT_STOP: begin
							// Already stationary means no wait at all
							if (i_motion.rotating) begin
								next_state = MPS_ST_WSTOP;
							end else begin
								next_advance = 1'b1;
							end
						end
						MPS_OP_WAIT_POS: begin
							if (!i_motion.rotating) begin
								fail_code = MPS_ERR_WPOS_STOPPED;
							end else if (start_passed) begin
								fail_code = MPS_ERR_WPOS_PASSED;
							end else begin
								next_target = i_cmd.data;
								next_wait_dir_neg = i_motion.dir_neg;
								next_state = MPS_ST_WPOS;
							end
						end
						MPS_OP_PAUSE: begin
							next_state = MPS_ST_PAUSE;
						end
						MPS_OP_LAUNCH_Y: begin
							// Only the X program may start Y
							if (i_axis_is_y) begin
								fail_code = MPS_ERR_WRONG_AXIS;
							end else if (!label_ok) begin
								fail_code = MPS_ERR_LABEL;
							end else begin
								next_y_start = 1'b1;
								next_y_label = req_label;
								next_advance = 1'b1;
							end
						end
						MPS_OP_JOIN_Y: begin
							if (i_axis_is_y) begin
								fail_code = MPS_ERR_WRONG_AXIS;
							end else if (i_y_running) begin
								next_state = MPS_ST_WJOIN;
							end else begin
								next_advance = 1'b1;
							end
						end
						MPS_OP_SPEED: begin
							// A stopped motor makes the line a no-op
							if (!i_motion.rotating) begin
								next_advance = 1'b1;
							end else if (is_scurve(i_motion.profile)) begin
								fail_code = MPS_ERR_SPD_SCURVE;
							end else if (!cont_move) begin
								fail_code = MPS_ERR_SPD_MOVE;
							end else if (!speed_ok) begin
								fail_code = MPS_ERR_SPD_RANGE;
							end else begin
								next_speed_wr = 1'b1;
								next_speed = req_speed;
								next_speed_ramp = (i_motion.profile
									!= MPS_PROF_CONST);
								next_advance = 1'b1;
							end
						end
						MPS_OP_SET_POS: begin
							// Rewriting counters under motion is refused
							if (i_motion.rotating) begin
								fail_code = MPS_ERR_POS_ROTATING;
							end else begin
								next_pos_wr = 1'b1;
								next_pos = i_cmd.data;
								next_advance = 1'b1;
							end
						end
						default: begin
							fail_code = MPS_ERR_BAD_OP;
						end
					endcase
				end
			end
			MPS_ST_WSTOP: begin
				if (!i_motion.rotating) begin
					next_state = MPS_ST_IDLE;
					next_advance = 1'b1;
				end
			end
			MPS_ST_WPOS: begin
				// Passage is checked first so a stop on the target counts
				if (wait_passed) begin
					next_state = MPS_ST_IDLE;
					next_advance = 1'b1;
				end else if (!i_motion.rotating) begin
					next_state = MPS_ST_IDLE;
					fail_code = MPS_ERR_WPOS_HALTED;
				end
			end
			MPS_ST_WJOIN: begin
				if (!i_y_running) begin
					next_state = MPS_ST_IDLE;
					next_advance = 1'b1;
				end
			end
			MPS_ST_PAUSE: begin
				// Only the host tool's continue or an abort can release a pause
				if (i_continue) begin
					next_state = MPS_ST_IDLE;
					next_advance = 1'b1;
				end
			end
			default: begin
				next_state = MPS_ST_IDLE;
			end
		endcase
		// Abort drops any wait without an answer
		if (i_abort) begin
			next_state = MPS_ST_IDLE;
			next_advance = 1'b0;
			fail_code = MPS_ERR_NONE;
			next_speed_wr = 1'b0;
			next_pos_wr = 1'b0;
			next_y_start = 1'b0;
		end
	end

	// Error flag and code: a new error wins over a program-start clear
	assign next_error = (fail_code != MPS_ERR_NONE);
	assign next_err_code = next_error ? fail_code
		: (i_prog_start ? MPS_ERR_NONE : o_err_code);

	// Sequencer state and wait context
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= MPS_ST_IDLE;
			target <= '0;
			wait_dir_neg <= 1'b0;
		end else begin
			state <= next_state;
			target <= next_target;
			wait_dir_neg <= next_wait_dir_neg;
		end
	end

	// Registered handshake and status outputs
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ready <= 1'b0;
			o_advance <= 1'b0;
			o_error <= 1'b0;
			o_err_code <= MPS_ERR_NONE;
			o_paused <= 1'b0;
		end else begin
			o_ready <= (next_state == MPS_ST_IDLE);
			o_advance <= next_advance;
			o_error <= next_error;
			o_err_code <= next_err_code;
			o_paused <= (next_state == MPS_ST_PAUSE);
		end
	end

	// Registered requests to the motion engine and the Y sequencer;
	// an error path never asserts a write, so counters and speed hold
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_speed_wr <= 1'b0;
			o_speed_ramp <= 1'b0;
			o_speed <= '0;
			o_pos_wr <= 1'b0;
			o_pos <= '0;
			o_y_start <= 1'b0;
			o_y_label <= MPS_LABEL_NONE;
		end else begin
			o_speed_wr <= next_speed_wr;
			o_speed_ramp <= next_speed_ramp;
			o_speed <= next_speed;
			o_pos_wr <= next_pos_wr;
			o_pos <= next_pos;
			o_y_start <= next_y_start;
			o_y_label <= next_y_label;
		end
	end
endmodule // mps_seq

//--- verif/mps_seq_properties.sv
// Concurrent checks on the ports of the program sequencer.
// Assumes one clock domain and the synchronous active-high reset.
module mps_seq_properties
	import mps_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_axis_is_y,
	input wire logic i_cmd_valid,
	input wire mps_pkg::mps_cmd_t i_cmd,
	input wire mps_pkg::mps_motion_t i_motion,
	input wire logic i_continue,
	input wire logic i_abort,
	input wire logic o_ready,
	input wire logic o_advance,
	input wire logic o_error,
	input wire mps_pkg::mps_err_t o_err_code,
	input wire logic o_paused,
	input wire logic o_speed_wr,
	input wire logic o_speed_ramp,
	input wire logic [mps_pkg::MPS_SPD_W-1:0] o_speed,
	input wire logic o_pos_wr,
	input wire logic o_y_start,
	input wire logic [mps_pkg::MPS_LABEL_W-1:0] o_y_label
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// A command is taken only from idle and when not aborted
	wire logic take = o_ready && i_cmd_valid && !i_abort;
	wire logic rot = i_motion.rotating;
	wire mps_prof_t prof = i_motion.profile;
	// Trapezoid profiles ramp, constant speed jumps
	wire logic trap = prof inside {MPS_PROF_TRAP1, MPS_PROF_TRAP2,
		MPS_PROF_TRAP3};
	// Upper speed limit for the present microstep setting
	wire logic [MPS_SPD_W-1:0] lim =
		(i_motion.microstep == MPS_USTEP_1) ? MPS_SPD_MAX_1 :
		(i_motion.microstep == MPS_USTEP_2) ? MPS_SPD_MAX_2 : MPS_SPD_MAX_N;

	chk_nop_advance: assert property (
		take && i_cmd.op == MPS_OP_NO_ACTION |=> o_advance && !o_error)
		else $error("no-action line did not advance");
	chk_stop_at_once: assert property (
		take && i_cmd.op == MPS_OP_WAIT_STOP && !rot |=> o_advance)
		else $error("stop wait on still motor did not advance");
	chk_pause_holds: assert property (
		o_paused && !i_continue && !i_abort |=> o_paused)
		else $error("pause left without continue");
	chk_speed_advance: assert property (
		o_speed_wr |-> o_advance && o_speed >= MPS_SPD_MIN)
		else $error("speed write without advance");
	chk_speed_ramp: assert property (
		o_speed_wr |-> o_speed_ramp == $past(trap) && $past(prof) <= 3)
		else $error("speed ramp kind wrong");
	chk_speed_limit: assert property (
		o_speed_wr |-> o_speed <= $past(lim))
		else $error("speed above limit");
	chk_pos_stopped: assert property (
		o_pos_wr |-> o_advance && !$past(rot))
		else $error("position written while rotating");
	chk_launch_x: assert property (
		o_y_start |-> o_advance && o_y_label != MPS_LABEL_NONE &&
		!$past(i_axis_is_y))
		else $error("bad second axis launch");
	chk_error_code: assert property (
		o_error |-> o_err_code != MPS_ERR_NONE && !o_advance)
		else $error("error without code");
endmodule // mps_seq_properties

//--- verif/mps_motion_model.sv
// Motion engine model: rotates on request, counts one pulse a cycle.
// Assumes the bench drives run, direction, profile, move and microstep.
module mps_motion_model
	import mps_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_dir_neg,
	input wire mps_pkg::mps_prof_t i_profile,
	input wire mps_pkg::mps_move_t i_move,
	input wire logic [3:0] i_ustep,
	input wire logic i_pos_wr,
	input wire logic [mps_pkg::MPS_POS_W-1:0] i_pos,
	output mps_pkg::mps_motion_t o_motion
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rot = 1'b0; // Rotation lags the run request by one cycle
	logic [MPS_POS_W-1:0] pos = '0; // Shared logical/real position
	// Position follows rotation; a write loads both counters at once
	always_ff @(posedge i_clk) begin
		rot <= i_run;
		if (i_pos_wr) begin
			pos <= i_pos;
		end else if (rot) begin
			pos <= i_dir_neg ? pos - 1 : pos + 1;
		end
	end
	assign o_motion = '{rot, i_dir_neg, pos, i_profile, i_move, i_ustep};
endmodule // mps_motion_model

//--- verif/tb_top.sv
// Self-checking bench for the program sequencer with a motion model.
// Assumes the checker and model files are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mps_pkg::*;
	logic i_clk, i_reset = 1, i_axis_is_y = 0, i_two_axis = 0;
	logic i_cmd_valid = 0, i_continue = 0, i_abort = 0;
	logic i_prog_start = 0, i_y_running = 0, run = 0, dir = 0;
	mps_cmd_t i_cmd = '0;
	mps_motion_t i_motion;
	mps_prof_t prof = MPS_PROF_CONST;
	mps_move_t move = MPS_MOVE_CONT;
	logic [3:0] ustep = 4'h4;
	logic o_ready, o_advance, o_error, o_paused, o_speed_wr;
	logic o_speed_ramp, o_pos_wr, o_y_start;
	mps_err_t o_err_code;
	logic [MPS_SPD_W-1:0] o_speed;
	logic [MPS_POS_W-1:0] o_pos;
	logic [MPS_LABEL_W-1:0] o_y_label;
	int error_cnt = 0, tests_run = 0;
	// Speed table: profile, move, microstep, speed, expected code
	typedef struct {mps_prof_t p; mps_move_t m; logic [3:0] u;
		logic [31:0] s; mps_err_t e;} mps_spd_case_t;
	mps_spd_case_t spd_tab [8] = '{
		'{MPS_PROF_CONST, MPS_MOVE_CONT, 4'h1, MPS_SPD_MAX_1, MPS_ERR_NONE},
		'{MPS_PROF_TRAP1, MPS_MOVE_ABS_CONT, 4'h2, MPS_SPD_MAX_2,
			MPS_ERR_NONE},
		'{MPS_PROF_TRAP2, MPS_MOVE_REL_CONT, 4'h3, MPS_SPD_MAX_N,
			MPS_ERR_NONE},
		'{MPS_PROF_TRAP3, MPS_MOVE_CONT, 4'h1, MPS_SPD_MAX_1 + 1,
			MPS_ERR_SPD_RANGE},
		'{MPS_PROF_CONST, MPS_MOVE_CONT, 4'h2, 32'h0, MPS_ERR_SPD_RANGE},
		'{MPS_PROF_SCURVE1, MPS_MOVE_CONT, 4'h4, 32'h64, MPS_ERR_SPD_SCURVE},
		'{MPS_PROF_SCURVE2, MPS_MOVE_CONT, 4'h4, 32'h64, MPS_ERR_SPD_SCURVE},
		'{MPS_PROF_CONST, MPS_MOVE_OTHER, 4'h4, 32'h64, MPS_ERR_SPD_MOVE}};

	mps_seq i_mps_seq (.i_clk, .i_reset, .i_axis_is_y, .i_two_axis,
		.i_cmd_valid, .i_cmd, .i_motion, .i_continue, .i_abort,
		.i_prog_start, .i_y_running, .o_ready, .o_advance, .o_error,
		.o_err_code, .o_paused, .o_speed_wr, .o_speed_ramp, .o_speed,
		.o_pos_wr, .o_pos, .o_y_start, .o_y_label);
	mps_motion_model i_mps_motion_model (.i_clk(i_clk), .i_run(run),
		.i_dir_neg(dir), .i_profile(prof), .i_move(move), .i_ustep(ustep),
		.i_pos_wr(o_pos_wr), .i_pos(o_pos), .o_motion(i_motion));

	// Clock at 125 MHz
	initial begin
		i_clk = 0;
		forever #4 i_clk = ~i_clk;
	end
	// Compare one result; an unknown never matches
	task automatic chk(input logic [31:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Offer one line for one rising edge, from a falling edge
	task automatic send(input mps_op_t op, input logic [31:0] d,
		input logic sy = 0);
		i_cmd = '{op, sy, d};
		i_cmd_valid = 1;
		@(negedge i_clk);
		i_cmd_valid = 0;
	endtask
	// Bounded wait for the line to end, then judge its outcome
	task automatic fin(input logic e, input mps_err_t c = MPS_ERR_NONE);
		int n;
		n = 0;
		while (o_advance !== 1'b1 && o_error !== 1'b1) begin
			if (++n > 2000) begin
				chk(0, 1, "timeout");
				give_verdict();
			end
			@(negedge i_clk);
		end
		chk(o_error, e, "error flag");
		if (e) chk(o_err_code, c, "error code");
	endtask
	task automatic t_nop();
		send(MPS_OP_NO_ACTION, 0);
		fin(0);
		send(MPS_OP_NO_ACTION, 0); // Back to back
		fin(0);
		send(mps_op_t'(4'h8), 0); // Opcode outside the set
		fin(1, MPS_ERR_BAD_OP);
	endtask
	task automatic t_wait_stop();
		send(MPS_OP_WAIT_STOP, 0);
		fin(0);
		run = 1;
		repeat (2) @(negedge i_clk);
		send(MPS_OP_WAIT_STOP, 0);
		repeat (5) @(negedge i_clk);
		chk(o_ready, 0, "stop wait held");
		run = 0;
		fin(0);
	endtask
	task automatic t_set_pos();
		run = 1;
		repeat (2) @(negedge i_clk);
		send(MPS_OP_SET_POS, 0);
		fin(1, MPS_ERR_POS_ROTATING);
		chk(o_pos_wr, 0, "no write");
		run = 0;
		i_prog_start = 1; // Clears the latched code
		repeat (2) @(negedge i_clk);
		i_prog_start = 0;
		chk(o_err_code, MPS_ERR_NONE, "code cleared");
		send(MPS_OP_SET_POS, 32'hFFFFFFF0); // Below zero on purpose
		fin(0);
		chk(o_pos_wr, 1, "pos write");
		chk(o_pos, 32'hFFFFFFF0, "pos value");
	endtask
	task automatic t_wait_pos();
		send(MPS_OP_WAIT_POS, 32'h5);
		fin(1, MPS_ERR_WPOS_STOPPED);
		run = 1;
		repeat (2) @(negedge i_clk);
		send(MPS_OP_WAIT_POS, 32'h4); // Crosses zero on the way
		fin(0);
		chk($signed(i_motion.position) >= 4, 1, "fwd pass");
		send(MPS_OP_WAIT_POS, 32'h0);
		fin(1, MPS_ERR_WPOS_PASSED);
		send(MPS_OP_WAIT_POS, 32'h3E8);
		repeat (5) @(negedge i_clk);
		run = 0;
		fin(1, MPS_ERR_WPOS_HALTED);
		dir = 1;
		run = 1;
		repeat (2) @(negedge i_clk);
		send(MPS_OP_WAIT_POS, 32'hA);
		fin(0);
		chk($signed(i_motion.position) <= 10, 1, "rev pass");
		run = 0;
		dir = 0;
	endtask
	task automatic t_pause();
		send(MPS_OP_PAUSE, 0); // Host-run program, never by select
		repeat (10) @(negedge i_clk);
		chk(o_paused, 1, "paused");
		chk(o_advance, 0, "no advance");
		i_continue = 1;
		fin(0);
		i_continue = 0;
		send(MPS_OP_PAUSE, 0);
		i_abort = 1; // Program ended elsewhere in mid-pause
		@(negedge i_clk);
		i_abort = 0;
		chk(o_paused, 0, "abort");
	endtask
	task automatic t_axes();
		send(MPS_OP_LAUNCH_Y, 32'h3F); // Y code under own label
		fin(0);
		chk(o_y_start, 1, "launch");
		chk(o_y_label, 32'h3F, "label");
		i_y_running = 1;
		send(MPS_OP_JOIN_Y, 0);
		repeat (5) @(negedge i_clk);
		chk(o_ready, 0, "join held");
		i_y_running = 0; // Y program reached its end line
		fin(0);
		send(MPS_OP_JOIN_Y, 0);
		fin(0);
		send(MPS_OP_LAUNCH_Y, 32'h40); // Label beyond the last one
		fin(1, MPS_ERR_LABEL);
		chk(o_y_start, 0, "no launch");
		i_axis_is_y = 1;
		send(MPS_OP_LAUNCH_Y, 32'h1);
		fin(1, MPS_ERR_WRONG_AXIS);
		i_two_axis = 1;
		send(MPS_OP_SET_POS, 32'h0, 1); // Standalone line is skipped
		fin(0);
		chk(o_pos_wr, 0, "ignored");
		i_axis_is_y = 0;
		i_two_axis = 0;
	endtask
	task automatic t_speed();
		run = 1;
		foreach (spd_tab[k]) begin
			prof = spd_tab[k].p;
			move = spd_tab[k].m;
			ustep = spd_tab[k].u;
			repeat (2) @(negedge i_clk);
			send(MPS_OP_SPEED, spd_tab[k].s);
			fin(spd_tab[k].e != MPS_ERR_NONE, spd_tab[k].e);
			chk(o_speed_wr, spd_tab[k].e == MPS_ERR_NONE, "wr");
			// Ramp kind only means something alongside a write
			if (spd_tab[k].e == MPS_ERR_NONE) begin
				chk(o_speed_ramp, spd_tab[k].p != MPS_PROF_CONST,
					"ramp");
				chk(o_speed, spd_tab[k].s, "speed value");
			end
		end
		run = 0;
		repeat (2) @(negedge i_clk);
		send(MPS_OP_SPEED, 32'h64); // Still motor: line just passes
		fin(0);
		chk(o_speed_wr, 0, "no write stopped");
	endtask
	initial begin
		repeat (20) @(negedge i_clk);
		i_reset = 0;
		@(negedge i_clk);
		i_prog_start = 1; // X program starts at its label
		@(negedge i_clk);
		i_prog_start = 0;
		t_nop();
		t_wait_stop();
		t_set_pos();
		t_wait_pos();
		t_pause();
		t_axes();
		t_speed();
		give_verdict();
	end
endmodule // tb_top

bind mps_seq mps_seq_properties i_mps_seq_properties (.i_clk, .i_reset,
	.i_axis_is_y, .i_cmd_valid, .i_cmd, .i_motion, .i_continue, .i_abort,
	.o_ready, .o_advance, .o_error, .o_err_code, .o_paused, .o_speed_wr,
	.o_speed_ramp, .o_speed, .o_pos_wr, .o_y_start, .o_y_label);
